// File: fvi_pkg.sv
package fvi_pkg;
   // Number of sources and width of a source index.
   localparam int NSRC = 13;
   localparam int SRC_W = 4;
   localparam int LVL_W = 3;
   // Avalon register word offsets (byte address = 4 x index).
   localparam logic [3:0] OFS_IE    = 4'h0;
   localparam logic [3:0] OFS_EIE   = 4'h1;
   localparam logic [3:0] OFS_IPL   = 4'h2;
   localparam logic [3:0] OFS_IPH   = 4'h3;
   localparam logic [3:0] OFS_EIPL  = 4'h4;
   localparam logic [3:0] OFS_EIPH  = 4'h5;
   localparam logic [3:0] OFS_FLAG  = 4'h6;
   localparam logic [3:0] OFS_MODE  = 4'h7;
   localparam logic [3:0] OFS_STAT  = 4'h8;
   localparam logic [3:0] OFS_ISTS  = 4'h9;
   localparam logic [3:0] OFS_IMSK  = 4'ha;
   // Bit positions in the IE and mode words.
   localparam int GIE_BIT   = 7;
   localparam int PF_EN_BIT = 5;
   // Flag word bit positions (source flags packed for software access).
   localparam int F_PF  = 0;
   localparam int F_X0  = 1;
   localparam int F_T0  = 2;
   localparam int F_X1  = 3;
   localparam int F_T1  = 4;
   localparam int F_R0  = 5;
   localparam int F_S0  = 6;
   localparam int F_T2  = 7;
   localparam int F_E2  = 8;
   localparam int F_R1  = 9;
   localparam int F_S1  = 10;
   localparam int F_X2  = 11;
   localparam int F_X3  = 12;
   localparam int F_X4  = 13;
   localparam int F_X5  = 14;
   localparam int F_WD  = 15;
   localparam int NFLAG = 16;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] IDLE_LVL = 3'h7;
   // Vector addresses by natural order.
   localparam logic [7:0] VEC [NSRC] = '{8'h33, 8'h03, 8'h0b, 8'h13,
      8'h1b, 8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
   // Sequencer states.
   typedef enum logic [1:0] {
      FVI_IDLE = 2'b00,
      FVI_WAIT = 2'b01
   } fvi_state_t;
endpackage

// File: fvi_arbiter.sv
`timescale 1ns/1ps
module fvi_arbiter
   import fvi_pkg::*;
(
   // Requests and levels.
   input  wire logic [NSRC-1:0]    req,
   input  wire logic [2*NSRC-1:0]  lvl,
   // Winner.
   output logic                    win_valid,
   output logic [SRC_W-1:0]        win_idx,
   output logic [LVL_W-1:0]        win_lvl
);
   // Scan from the last source down so the earliest in order wins ties.
   always_comb begin
      win_valid = 1'b0;
      win_idx   = '0;
      win_lvl   = '0;
      for (int i = NSRC-1; i >= 0; i--) begin
         if (req[i] && (!win_valid ||
             {1'b0, lvl[2*i +: 2]} >= win_lvl)) begin
            win_valid = 1'b1;
            win_idx   = SRC_W'(i);
            win_lvl   = {1'b0, lvl[2*i +: 2]};
         end
      end
   end
endmodule // fvi_arbiter

// File: fvi_unit.sv
`timescale 1ns/1ps
module fvi_unit
   import fvi_pkg::*;
(
   // Clock and reset.
   input  wire logic               mclk,
   input  wire logic               rst_n,
   // Avalon-MM slave.
   input  wire logic [5:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   // Event pulses from peripherals, one bit per flag position.
   input  wire logic [NFLAG-1:0]   evt_set,
   // External pins 0 and 1, asynchronous.
   input  wire logic [1:0]         ext_pin_n,
   // Core sequencer.
   input  wire logic               core_ack,
   input  wire logic               core_reti,
   output logic                    irq_req,
   output logic [7:0]              irq_vector,
   output logic [LVL_W-1:0]        run_level,
   // Interrupt to system.
   output logic                    irq
);
   logic [7:0]       ie, extended_irq_enable_reg, ipl, iph, eipl, eiph;
   logic [1:0]       ext_mode;
   logic             pf_en;
   logic [NFLAG-1:0] flag, next_flag;
   logic [1:0]       pin_s1, pin_s2, pin_d;
   logic [1:0]       ists, imsk;
   logic [7:0]       next_ie, next_eie, next_ipl, next_iph;
   logic [7:0]       next_eipl, next_eiph;
   logic [1:0]       next_mode, next_ists, next_imsk;
   logic             next_pf_en;
   logic [31:0]      next_rdata;
   logic             next_wait;
   logic [NSRC-1:0]  src_req, src_en;
   logic [2*NSRC-1:0] src_lvl;
   logic [NSRC-1:0]  raw;
   logic             win_valid;
   logic [SRC_W-1:0] win_idx;
   logic [LVL_W-1:0] win_lvl, eff_lvl;
   fvi_state_t       state, next_state;
   logic [LVL_W-1:0] stk [5];
   logic [2:0]       sp, next_sp;
   logic [LVL_W-1:0] next_run;
   logic             next_irq_req, next_irq;
   logic [7:0]       next_vec;
   logic [SRC_W-1:0] taken, next_taken;
   logic             wr, rd, vec_now;
   logic [1:0]       pin_fall;

   // A write lands at the edge where waitrequest is seen low; a read is
   // taken while waitrequest is high so that its data stand a cycle later.
   assign wr = avs_write && !avs_waitrequest;
   assign rd = avs_read && avs_waitrequest;
   assign vec_now = (state == FVI_WAIT) && core_ack;

   // Two-flop synchronisers for the external pins.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 2'h3;
         pin_s2 <= 2'h3;
         pin_d  <= 2'h3;
      end else begin
         pin_s1 <= ext_pin_n;
         pin_s2 <= pin_s1;
         pin_d  <= pin_s2;
      end
   end
   assign pin_fall = pin_d & ~pin_s2;

   // Per-source raw request, enable and level in natural order.
   always_comb begin
      raw[0]  = flag[F_PF];
      raw[1]  = flag[F_X0];
      raw[2]  = flag[F_T0];
      raw[3]  = flag[F_X1];
      raw[4]  = flag[F_T1];
      raw[5]  = flag[F_R0] | flag[F_S0];
      raw[6]  = flag[F_T2] | flag[F_E2];
      raw[7]  = flag[F_R1] | flag[F_S1];
      raw[8]  = flag[F_X2];
      raw[9]  = flag[F_X3];
      raw[10] = flag[F_X4];
      raw[11] = flag[F_X5];
      raw[12] = flag[F_WD];
      src_en  = {extended_irq_enable_reg[4:0], ie[6:0], 1'b0};
      src_lvl = '0;
      for (int i = 1; i < NSRC; i++) begin
         if (i < 8) begin
            src_lvl[2*i +: 2] = {iph[i-1], ipl[i-1]};
         end else begin
            src_lvl[2*i +: 2] = {eiph[i-8], eipl[i-8]};
         end
      end
      src_req = raw & src_en & {NSRC{ie[GIE_BIT]}};
      src_req[0] = raw[0] & pf_en;
   end

   fvi_arbiter u_arb (
      .req       (src_req),
      .lvl       (src_lvl),
      .win_valid (win_valid),
      .win_idx   (win_idx),
      .win_lvl   (win_lvl)
   );
   // Power-fail always sits alone at level 4.
   assign eff_lvl = src_req[0] ? 3'h4 : win_lvl;

   // Flags: events set, software clears, vectoring auto-clears some.
   always_comb begin
      next_flag = flag;
      if (wr && avs_address[5:2] == OFS_FLAG) begin
         next_flag = flag & ~avs_writedata[NFLAG-1:0];
      end
      if (vec_now) begin
         unique case (taken)
            4'h2: next_flag[F_T0] = 1'b0;
            4'h4: next_flag[F_T1] = 1'b0;
            4'h1: next_flag[F_X0] = 1'b0;
            4'h3: next_flag[F_X1] = 1'b0;
            default: next_flag = next_flag;
         endcase
      end
      next_flag = next_flag | evt_set;
      next_flag[F_X0] = next_flag[F_X0] | pin_fall[0];
      next_flag[F_X1] = next_flag[F_X1] | pin_fall[1];
      if (!ext_mode[0]) next_flag[F_X0] = ~pin_s2[0];
      if (!ext_mode[1]) next_flag[F_X1] = ~pin_s2[1];
   end

   // Bus register writes, read mux and one wait state.
   always_comb begin
      next_ie = ie;
      next_eie = extended_irq_enable_reg;
      next_ipl = ipl;
      next_iph = iph;
      next_eipl = eipl;
      next_eiph = eiph;
      next_mode = ext_mode;
      next_pf_en = pf_en;
      next_imsk = imsk;
      next_ists = ists & ~((wr && avs_address[5:2] == OFS_ISTS) ?
                  avs_writedata[1:0] : 2'h0);
      next_ists = next_ists | {vec_now, |(evt_set | {14'h0, pin_fall})};
      next_rdata = 32'h0;
      next_wait = !(avs_read || avs_write) || !avs_waitrequest;
      if (wr) begin
         unique case (avs_address[5:2])
            OFS_IE:   next_ie = avs_writedata[7:0];
            OFS_EIE:  next_eie = avs_writedata[7:0] & 8'h1f;
            OFS_IPL:  next_ipl = avs_writedata[7:0] & 8'h7f;
            OFS_IPH:  next_iph = avs_writedata[7:0] & 8'h7f;
            OFS_EIPL: next_eipl = avs_writedata[7:0] & 8'h1f;
            OFS_EIPH: next_eiph = avs_writedata[7:0] & 8'h1f;
            OFS_MODE: begin
               next_mode = avs_writedata[1:0];
               next_pf_en = avs_writedata[PF_EN_BIT];
            end
            OFS_IMSK: next_imsk = avs_writedata[1:0];
            default: next_imsk = next_imsk;
         endcase
      end
      if (rd) begin
         unique case (avs_address[5:2])
            OFS_IE:   next_rdata = {24'h0, ie};
            OFS_EIE:  next_rdata = {24'h0, extended_irq_enable_reg};
            OFS_IPL:  next_rdata = {24'h0, ipl};
            OFS_IPH:  next_rdata = {24'h0, iph};
            OFS_EIPL: next_rdata = {24'h0, eipl};
            OFS_EIPH: next_rdata = {24'h0, eiph};
            OFS_FLAG: next_rdata = {16'h0, flag};
            OFS_MODE: next_rdata = {26'h0, pf_en, 3'h0, ext_mode};
            OFS_STAT: next_rdata = {24'h0, sp, 1'b0, run_level, irq_req};
            OFS_ISTS: next_rdata = {30'h0, ists};
            OFS_IMSK: next_rdata = {30'h0, imsk};
            default:  next_rdata = 32'h0;
         endcase
      end
      next_irq = |(next_ists & next_imsk);
   end

   // Request sequencer with a nesting stack of running levels.
   always_comb begin
      next_state = state;
      next_sp = sp;
      next_run = run_level;
      next_irq_req = 1'b0;
      next_vec = irq_vector;
      next_taken = taken;
      unique case (state)
         FVI_IDLE: begin
            // Only a strictly higher level may preempt.
            if ((src_req != '0) && (sp == 3'h0 ||
                eff_lvl > run_level)) begin
               next_state = FVI_WAIT;
               next_taken = src_req[0] ? 4'h0 : win_idx;
               next_vec = VEC[next_taken];
               next_irq_req = 1'b1;
            end
         end
         FVI_WAIT: begin
            next_irq_req = !core_ack;
            if (core_ack) begin
               next_state = FVI_IDLE;
               next_sp = sp + 3'h1;
               next_run = (taken == 4'h0) ? 3'h4 :
                          {1'b0, src_lvl[2*taken +: 2]};
            end
         end
         default: next_state = FVI_IDLE;
      endcase
      if (core_reti && state == FVI_IDLE && sp != 3'h0) begin
         next_sp = sp - 3'h1;
         next_run = (sp > 3'h1) ? stk[sp-3'h2] : IDLE_LVL;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= '0;
         ie <= RST_BYTE;
         extended_irq_enable_reg <= RST_BYTE;
         ipl <= RST_BYTE;
         iph <= RST_BYTE;
         eipl <= RST_BYTE;
         eiph <= RST_BYTE;
         ext_mode <= 2'h0;
         pf_en <= 1'b0;
         ists <= 2'h0;
         imsk <= 2'h0;
         irq <= 1'b0;
         avs_readdata <= 32'h0;
         avs_waitrequest <= 1'b1;
         state <= FVI_IDLE;
         sp <= 3'h0;
         run_level <= IDLE_LVL;
         irq_req <= 1'b0;
         irq_vector <= 8'h00;
         taken <= '0;
         for (int i = 0; i < 5; i++) stk[i] <= IDLE_LVL;
      end else begin
         flag <= next_flag;
         ie <= next_ie;
         extended_irq_enable_reg <= next_eie;
         ipl <= next_ipl;
         iph <= next_iph;
         eipl <= next_eipl;
         eiph <= next_eiph;
         ext_mode <= next_mode;
         pf_en <= next_pf_en;
         ists <= next_ists;
         imsk <= next_imsk;
         irq <= next_irq;
         avs_readdata <= next_rdata;
         avs_waitrequest <= next_wait;
         state <= next_state;
         sp <= next_sp;
         run_level <= next_run;
         irq_req <= next_irq_req;
         irq_vector <= next_vec;
         taken <= next_taken;
         if (next_sp > sp) stk[sp] <= next_run;
      end
   end

   // Checks on gating, ordering and vectoring.
   gie_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !ie[GIE_BIT] && state == FVI_IDLE && sp == 3'h0 |=>
      !irq_req || irq_vector == 8'h33)
      else $error("Request taken while globally disabled.");
   pf_vec_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state == FVI_IDLE && src_req[0] && sp == 3'h0 |=>
      irq_vector == 8'h33 && irq_req)
      else $error("Power-fail not vectored to 33h.");
   t0_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      vec_now && taken == 4'h2 && !evt_set[F_T0] |=> !flag[F_T0])
      else $error("Timer 0 flag survived vectoring.");
   ser_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
      flag[F_R0] && !wr |=> flag[F_R0])
      else $error("Serial flag cleared by hardware.");
   preempt_a: assert property (@(posedge mclk) disable iff (!rst_n)
      state == FVI_IDLE && sp != 3'h0 && eff_lvl <= run_level |=>
      state == FVI_IDLE)
      else $error("Equal or lower level preempted.");
   ack_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
      vec_now |=> !irq_req && sp == $past(sp) + 3'h1)
      else $error("Acknowledge not completed.");
   evt_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
      evt_set[F_WD] |=> flag[F_WD])
      else $error("Event lost.");
   bus_ans_a: assert property (@(posedge mclk) disable iff (!rst_n)
      avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("Bus answer late.");
   vec_c: cover property (@(posedge mclk) disable iff (!rst_n) vec_now);
   nest_c: cover property (@(posedge mclk) disable iff (!rst_n)
      sp == 3'h2);
   irq_c: cover property (@(posedge mclk) disable iff (!rst_n) irq);
endmodule // fvi_unit

// File: fvi_core_model.sv
`timescale 1ns/1ps
module fvi_core_model (
   // Clock and reset.
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Request from the unit.
   input  wire logic       irq_req,
   input  wire logic [7:0] irq_vector,
   // Bench controls.
   input  wire logic [3:0] ack_wait,
   input  wire logic       reti_go,
   // Answers and record.
   output logic            core_ack,
   output logic            core_reti,
   output logic [7:0]      last_vec,
   output logic [7:0]      n_taken
);
   logic [3:0] cnt;
   // Accepts a request after ack_wait cycles and logs its vector.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         core_ack <= 1'b0;
         core_reti <= 1'b0;
         last_vec <= 8'h00;
         n_taken <= 8'h00;
         cnt <= 4'h0;
      end else begin
         core_ack <= 1'b0;
         core_reti <= reti_go;
         cnt <= 4'h0;
         if (irq_req && !core_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt >= ack_wait) begin
               core_ack <= 1'b1;
               last_vec <= irq_vector;
               n_taken <= n_taken + 8'h01;
               cnt <= 4'h0;
            end
         end
      end
   end
endmodule // fvi_core_model

// File: five_level_vectored_interrupt_unit_bench.sv
`timescale 1ns/1ps
module five_level_vectored_interrupt_unit_bench;
   import fvi_pkg::*;
   logic             mclk = 1'b0;
   logic             rst_n = 1'b0;
   logic [5:0]       avs_address = 6'h00;
   logic             avs_read = 1'b0;
   logic             avs_write = 1'b0;
   logic [31:0]      avs_writedata = 32'h0;
   logic [31:0]      avs_readdata;
   logic [31:0]      q;
   logic             avs_waitrequest;
   logic [NFLAG-1:0] evt_set = '0;
   logic [1:0]       ext_pin_n = 2'h3;
   logic             core_ack, core_reti, irq_req, irq;
   logic [7:0]       irq_vector, last_vec, n_taken;
   logic [7:0]       seen = 8'h00;
   logic [2:0]       run_level;
   logic [3:0]       ack_wait = 4'h0;
   logic             reti_go = 1'b0;
   int               n_fail = 0;
   int               total_checks = 0;
   logic [7:0] vec_t [13] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b,
      8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
   int flg_t [13] = '{F_PF, F_X0, F_T0, F_X1, F_T1, F_S0, F_E2,
      F_S1, F_X2, F_X3, F_X4, F_X5, F_WD};

   // Clock of 50 ns.
   always #25 mclk = ~mclk;

   fvi_unit dut_u (.mclk(mclk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .evt_set(evt_set), .ext_pin_n(ext_pin_n), .core_ack(core_ack),
      .core_reti(core_reti), .irq_req(irq_req),
      .irq_vector(irq_vector), .run_level(run_level), .irq(irq));

   fvi_core_model core_u (.mclk(mclk), .rst_n(rst_n),
      .irq_req(irq_req), .irq_vector(irq_vector), .ack_wait(ack_wait),
      .reti_go(reti_go), .core_ack(core_ack), .core_reti(core_reti),
      .last_vec(last_vec), .n_taken(n_taken));

   // Compares and counts.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [3:0] ix,
                      input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= {ix, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      chk(n < 40, 1'b1);
      q = avs_readdata;
      // Released right after the answering edge, then one idle edge.
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rdc(input logic [3:0] ix, input logic [31:0] e);
      bus(1'b0, ix, 32'h0);
      chk(q, e);
   endtask

   task automatic pulse(input logic [15:0] m);
      evt_set <= m;
      @(posedge mclk);
      evt_set <= '0;
   endtask

   // Waits for the core to accept a vector, then compares it.
   task automatic take(input logic [7:0] ev);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (n_taken === seen && n < 40);
      chk(n < 40, 1'b1);
      seen = n_taken;
      chk(last_vec, ev);
      // Lets the acknowledge land in the unit before anything is checked.
      repeat (2) @(posedge mclk);
   endtask

   // Checks that nothing is accepted for a while.
   task automatic idle_chk();
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      chk(n_taken, seen);
      @(posedge mclk);
   endtask

   task automatic reti();
      reti_go <= 1'b1;
      @(posedge mclk);
      reti_go <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask

   task automatic irqc(input logic e);
      repeat (2) @(posedge mclk);
      chk(irq, e);
   endtask

   // Prints counts and the verdict, then stops.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Main sequence.
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk(run_level, IDLE_LVL);
      chk({irq_req, irq}, 2'b00);
      rdc(OFS_IE, 32'h0);
      rdc(4'hf, 32'h0);
      $display("test reset done");
      bus(1'b1, OFS_IE, 32'h7f);
      bus(1'b1, OFS_EIE, 32'h1f);
      pulse(16'h0080);
      idle_chk();
      rdc(OFS_FLAG, 32'h80);
      bus(1'b1, OFS_FLAG, 32'h80);
      $display("test global gate done");
      for (int i = 0; i < 13; i++) begin
         bus(1'b1, OFS_IE, i == 0 ? 0 : (i < 8 ? 32'h80 | 1 << (i - 1)
            : 32'h80));
         bus(1'b1, OFS_EIE, i >= 8 ? 1 << (i - 8) : 0);
         bus(1'b1, OFS_MODE, i == 0 ? 32'h23 : 32'h03);
         if (i == 1 || i == 3)
            ext_pin_n[i / 2] <= 1'b0;
         else
            pulse(16'h1 << flg_t[i]);
         take(vec_t[i]);
         chk(run_level, i == 0 ? 4 : 0);
         rdc(OFS_FLAG, (i>0 && i<5) ? 0 : 1 << flg_t[i]);
         ext_pin_n <= 2'h3;
         bus(1'b1, OFS_FLAG, 32'hffff);
         reti();
         chk(run_level, IDLE_LVL);
      end
      $display("test vectors done");
      bus(1'b1, OFS_IE, 32'hf0);
      for (int k = 0; k < 3; k++) begin
         pulse(16'h1 << (k == 0 ? F_R0 : (k == 1 ? F_T2 : F_R1)));
         take(k == 0 ? 8'h23 : (k == 1 ? 8'h2b : 8'h3b));
         bus(1'b1, OFS_FLAG, 32'hffff);
         reti();
      end
      $display("test second flags done");
      ack_wait <= 4'h3;
      bus(1'b1, OFS_IE, 32'h80);
      bus(1'b1, OFS_EIE, 32'h03);
      pulse(16'h1800);
      take(8'h43);
      bus(1'b1, OFS_FLAG, 32'h0800);
      reti();
      take(8'h4b);
      bus(1'b1, OFS_FLAG, 32'h1000);
      reti();
      bus(1'b1, OFS_EIPL, 32'h02);
      bus(1'b1, OFS_EIPH, 32'h02);
      pulse(16'h1800);
      take(8'h4b);
      chk(run_level, 3'h3);
      rdc(OFS_STAT, 32'h26);
      idle_chk();
      bus(1'b1, OFS_MODE, 32'h23);
      pulse(16'h0001);
      take(8'h33);
      bus(1'b1, OFS_FLAG, 32'h1001);
      reti();
      chk(run_level, 3'h3);
      reti();
      take(8'h43);
      bus(1'b1, OFS_FLAG, 32'h0800);
      reti();
      $display("test priority done");
      bus(1'b1, OFS_IE, 32'h0);
      bus(1'b1, OFS_MODE, 32'h0);
      ext_pin_n <= 2'h2;
      repeat (4) @(posedge mclk);
      rdc(OFS_FLAG, 32'h2);
      ext_pin_n <= 2'h3;
      repeat (4) @(posedge mclk);
      rdc(OFS_FLAG, 32'h0);
      $display("test level mode done");
      bus(1'b1, OFS_ISTS, 32'h3);
      bus(1'b1, OFS_IMSK, 32'h0);
      bus(1'b1, OFS_IE, 32'h82);
      pulse(16'h0004);
      take(8'h0b);
      irqc(1'b0);
      bus(1'b1, OFS_IMSK, 32'h2);
      irqc(1'b1);
      bus(1'b1, OFS_ISTS, 32'h3);
      irqc(1'b0);
      reti();
      $display("test irq output done");
      wrap_up();
   end

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      wrap_up();
   end
endmodule // five_level_vectored_interrupt_unit_bench
